// file: verilog/uss_port.sv
/*
  Synchronous slave serial port: external shift clock, one shared data pin,
  transmit holding and shift registers, receive shift register and queue.
  Assumes the shift clock pin is far slower than i_clk (several cycles per
  phase) and that software follows the documented setup order.
*/
// Strobed register access was chosen for this implementation.
// Overview of operation
// (RULE_01) Clock source select clear: shift clock comes from the external pin.
// (RULE_02) Port keeps shifting while the core sleeps; nothing here stops on sleep.
// (RULE_03) Slave transmit behaves as master transmit, clock supplied externally.
// (RULE_04) First written word moves to shift register; second waits, transmit flag clear.
// (RULE_05) After first word shifts out, held word moves over; transmit flag sets.
// (RULE_06) Transmit flag with its enable wakes the chip; global enable branches.
// (RULE_07) Software sets up transmit: mode, enable, clock select, data, then enable.
// (RULE_08) Software best loads holding register before setting transmit enable.
// (RULE_09) Clearing port enable or transmit enable aborts and resets transmit logic.
// (RULE_10) Single receive enable is ignored in slave mode.
// (RULE_11) Continuous receive completes words in sleep, fills buffer, sets receive flag.
// (RULE_12) Receive flag with its enable wakes the chip; global enable branches.
// (RULE_13) Software sets up receive: mode, enable, options, then continuous receive.
// (RULE_14) Software reads status before data and clears errors via continuous receive.
// (RULE_15) Clearing port or continuous receive enable aborts and resets receive logic.
// (RULE_16) Incoming data pin is sampled on the falling shift clock edge.
// (RULE_17) Receive buffer is two deep; third word when full sets overrun, dropped.
// (RULE_18) Overrun blocks transfers; clearing continuous receive clears overrun.
// (RULE_19) Reading received data shows ninth bit and framing flag of next word.
// (RULE_20) Ninth bit shifts right after eight data bits, least significant first.
// (RULE_21) Shift register empty reads one when idle, zero while shifting.
`timescale 1ns/1ps
`default_nettype none
module uss_port (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_bank,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ck_pin,
  input wire logic i_dt_in,
  output logic o_dt_out,
  output logic o_dt_oe,
  input wire logic i_glob_int_en,
  output logic o_wake,
  output logic o_irq,
  output logic [15:0] o_vector
);
  // Control registers
  logic port_en, rx_nine, single_rx, cont_rx, overrun;
  logic clk_src, tx_nine, tx_en, sync_mode, tx_bit9;
  logic tx_int_en, rx_int_en;
  logic [7:0] divisor;
  // Transmit path
  logic [7:0] thr;
  logic tx_full;
  logic [8:0] tx_shift;
  logic tsr_busy;
  logic [3:0] tx_cnt;
  logic tx_smp;
  // Receive path
  logic [8:0] rx_shift;
  logic [3:0] rx_cnt;
  // Pins after synchronising, and the previous clock level
  logic ck_s, dt_s, ck_d;

  uss_sync2 u_sync_ck (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_ck_pin),
    .o_sync(ck_s)
  );
  uss_sync2 u_sync_dt (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_dt_in),
    .o_sync(dt_s)
  );

  // Shift clock edges, found on the synchronised pin
  wire ck_rise = ck_s & ~ck_d;
  wire ck_fall = ~ck_s & ck_d;

  // Mode decode: slave only when clock source select is clear
  wire slave = port_en & sync_mode & ~clk_src; // RULE_01
  wire tx_go = slave & tx_en & ~cont_rx; // RULE_03 RULE_09
  wire rx_go = slave & cont_rx; // RULE_10 RULE_15

  // Register strobes
  wire b0 = (i_bank == uss_pkg::BANK0);
  wire b1 = (i_bank == uss_pkg::BANK1);
  wire wr_rx_ctl = i_wr & b0 & (i_addr == uss_pkg::RXCTL_ADDR);
  wire wr_tx_ctl = i_wr & b0 & (i_addr == uss_pkg::TXCTL_ADDR);
  wire wr_thr = i_wr & b0 & (i_addr == uss_pkg::TXHOLD_ADDR);
  wire wr_div = i_wr & b0 & (i_addr == uss_pkg::DIVISOR_ADDR);
  wire wr_inten = i_wr & b1 & (i_addr == uss_pkg::INTEN_ADDR);
  wire rd_rxbuf = i_rd & b0 & (i_addr == uss_pkg::RXBUF_ADDR);

  // Transmit sequencing
  wire [3:0] tx_last_idx = tx_nine ? uss_pkg::LAST_BIT_9 : uss_pkg::LAST_BIT_8; // RULE_20
  wire tx_load = tx_go & tx_full & ~tsr_busy; // RULE_04 RULE_05
  wire tx_end = tx_go & tsr_busy & ck_fall & (tx_cnt == tx_last_idx);
  wire tx_flag = ~tx_full; // RULE_04 RULE_05

  // Receive sequencing
  wire [3:0] rx_last_idx = rx_nine ? uss_pkg::LAST_BIT_9 : uss_pkg::LAST_BIT_8;
  wire [8:0] next_rx_shift = {dt_s, rx_shift[8:1]};
  wire rx_done = rx_go & ck_fall & (rx_cnt == rx_last_idx); // RULE_11
  wire [7:0] rx_byte = rx_nine ? next_rx_shift[7:0] : next_rx_shift[8:1];
  wire rx_bit9 = rx_nine & next_rx_shift[8];
  wire q_full, q_empty;
  wire [uss_pkg::RXQ_WIDTH-1:0] q_head;
  wire q_push = rx_done & ~overrun & ~q_full; // RULE_17 RULE_18
  wire q_pop = rd_rxbuf & ~q_empty; // RULE_19
  wire rx_flag = ~q_empty; // RULE_11

  uss_rxq u_rxq (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_push(q_push),
    .i_data({1'b0, rx_bit9, rx_byte}),
    .i_pop(q_pop),
    .o_data(q_head),
    .o_empty(q_empty),
    .o_full(q_full)
  );

  // Read views of the status registers; the queue head supplies the ninth bit and framing flag
  wire [7:0] rx_ctl_v = {port_en, rx_nine, single_rx, cont_rx, 1'b0, q_head[9], overrun,
    q_head[8]}; // RULE_19
  wire [7:0] tx_ctl_v = {clk_src, tx_nine, tx_en, sync_mode, 2'h0, ~tsr_busy, tx_bit9}; // RULE_21
  wire [7:0] intreq_v = {6'h00, tx_flag, rx_flag};
  wire [7:0] inten_v = {6'h00, tx_int_en, rx_int_en};
  wire [7:0] rd_mux =
    (b0 && i_addr == uss_pkg::RXCTL_ADDR) ? rx_ctl_v :
    (b0 && i_addr == uss_pkg::RXBUF_ADDR) ? q_head[7:0] :
    (b0 && i_addr == uss_pkg::TXCTL_ADDR) ? tx_ctl_v :
    (b0 && i_addr == uss_pkg::DIVISOR_ADDR) ? divisor :
    (b1 && i_addr == uss_pkg::INTREQ_ADDR) ? intreq_v :
    (b1 && i_addr == uss_pkg::INTEN_ADDR) ? inten_v : uss_pkg::ZERO8;

  // Software-written control bits
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {port_en, rx_nine, single_rx, cont_rx} <= uss_pkg::RXCTL_RST[7:4];
      {clk_src, tx_nine, tx_en, sync_mode} <= uss_pkg::TXCTL_RST[7:4];
      tx_bit9 <= uss_pkg::TXCTL_RST[uss_pkg::TX_BIT9];
      {tx_int_en, rx_int_en} <= uss_pkg::INTEN_RST;
      divisor <= uss_pkg::DIVISOR_RST;
    end else begin
      if (wr_rx_ctl) begin
        {port_en, rx_nine, single_rx, cont_rx} <= i_wdata[uss_pkg::RC_PORT_EN:uss_pkg::RC_CONT];
      end
      if (wr_tx_ctl) begin
        {clk_src, tx_nine, tx_en, sync_mode} <= i_wdata[uss_pkg::TX_CLK_SRC:uss_pkg::TX_SYNC];
        tx_bit9 <= i_wdata[uss_pkg::TX_BIT9];
      end
      if (wr_inten) begin
        tx_int_en <= i_wdata[uss_pkg::IR_TX];
        rx_int_en <= i_wdata[uss_pkg::IR_RX];
      end
      if (wr_div) begin
        divisor <= i_wdata;
      end
    end
  end

  // Holding register; a write wins over a same-cycle transfer out
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr <= uss_pkg::ZERO8;
      tx_full <= 1'b0;
    end else if (wr_thr) begin
      thr <= i_wdata;
      tx_full <= 1'b1;
    end else if (tx_load) begin
      tx_full <= 1'b0; // RULE_05
    end
  end

  // Transmit shifter: bit held until the master's falling edge, moved on the next rise
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_shift <= 9'h000;
      tsr_busy <= 1'b0;
      tx_cnt <= 4'h0;
      tx_smp <= 1'b0;
    end else if (!tx_go) begin
      tsr_busy <= 1'b0; // RULE_09
      tx_cnt <= 4'h0;
      tx_smp <= 1'b0;
    end else if (tx_load) begin
      tx_shift <= {tx_bit9, thr}; // RULE_04 RULE_20
      tsr_busy <= 1'b1;
      tx_cnt <= 4'h0;
      tx_smp <= 1'b0;
    end else if (tsr_busy) begin
      if (tx_end) begin
        tsr_busy <= 1'b0; // RULE_21
      end else if (ck_fall) begin
        tx_smp <= 1'b1;
      end else if (ck_rise && tx_smp) begin
        tx_shift <= {1'b0, tx_shift[8:1]};
        tx_cnt <= tx_cnt + uss_pkg::CNT_ONE;
        tx_smp <= 1'b0;
      end
    end
  end

  // Receive shifter, sampling the data pin on each falling edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_shift <= 9'h000;
      rx_cnt <= 4'h0;
    end else if (!rx_go) begin
      rx_cnt <= 4'h0; // RULE_15
    end else if (ck_fall) begin
      rx_shift <= next_rx_shift; // RULE_16
      rx_cnt <= rx_done ? 4'h0 : rx_cnt + uss_pkg::CNT_ONE;
    end
  end

  // Overrun: set by a word that finds the queue full, cleared with receive
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      overrun <= 1'b0;
    end else if (!rx_go) begin
      overrun <= 1'b0; // RULE_18
    end else if (rx_done && q_full) begin
      overrun <= 1'b1; // RULE_17
    end
  end

  // Pin drive, read data and wake; these run whether or not the core sleeps
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ck_d <= 1'b0;
      o_dt_out <= 1'b1;
      o_dt_oe <= 1'b0;
      o_rdata <= uss_pkg::ZERO8;
      o_wake <= 1'b0;
      o_irq <= 1'b0;
      o_vector <= uss_pkg::INT_VECTOR;
    end else begin
      ck_d <= ck_s;
      o_dt_out <= tsr_busy ? tx_shift[0] : 1'b1;
      o_dt_oe <= tsr_busy & tx_go;
      o_rdata <= i_rd ? rd_mux : uss_pkg::ZERO8;
      o_wake <= (tx_flag & tx_int_en) | (rx_flag & rx_int_en); // RULE_02 RULE_06 RULE_12
      o_irq <= ((tx_flag & tx_int_en) | (rx_flag & rx_int_en)) & i_glob_int_en; // RULE_06 RULE_12
      o_vector <= uss_pkg::INT_VECTOR;
    end
  end

  property p_master_idle;
    @(posedge i_clk) disable iff (!i_rst_b) !slave |=> !tsr_busy && rx_cnt == 4'h0;
  endproperty
  a_master_idle: assert property (p_master_idle) else $error("shifting outside slave mode"); // RULE_01

  property p_tx_abort;
    @(posedge i_clk) disable iff (!i_rst_b) (!port_en || !tx_en) |=> !tsr_busy ##1 !o_dt_oe;
  endproperty
  a_tx_abort: assert property (p_tx_abort) else $error("transmit not reset on abort"); // RULE_09

  property p_first_load;
    @(posedge i_clk) disable iff (!i_rst_b)
      tx_go && tx_full && !tsr_busy && !wr_thr |=> tsr_busy && tx_flag;
  endproperty
  a_first_load: assert property (p_first_load) else $error("held word not moved to shifter"); // RULE_04

  property p_second_load;
    @(posedge i_clk) disable iff (!i_rst_b)
      tx_end && tx_full ##1 tx_go |=> tsr_busy;
  endproperty
  a_second_load: assert property (p_second_load) else $error("second word not loaded"); // RULE_05

  property p_empty_bit;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_rd && b0 && i_addr == uss_pkg::TXCTL_ADDR |=> o_rdata[uss_pkg::TX_EMPTY] == !$past(tsr_busy);
  endproperty
  a_empty_bit: assert property (p_empty_bit) else $error("shift empty bit wrong"); // RULE_21

  property p_wake;
    @(posedge i_clk) disable iff (!i_rst_b)
      (tx_flag && tx_int_en) || (rx_flag && rx_int_en) |=> o_wake ##0 (o_irq == $past(i_glob_int_en));
  endproperty
  a_wake: assert property (p_wake) else $error("wake or interrupt missing"); // RULE_06 RULE_12

  property p_rx_complete;
    @(posedge i_clk) disable iff (!i_rst_b) rx_done && !q_full && !overrun |=> rx_flag;
  endproperty
  a_rx_complete: assert property (p_rx_complete) else $error("receive flag not set"); // RULE_11

  property p_overrun;
    @(posedge i_clk) disable iff (!i_rst_b) rx_done && q_full |-> !q_push ##1 overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RULE_17

  property p_overrun_error_flag_block;
    @(posedge i_clk) disable iff (!i_rst_b) overrun && rx_go |-> !q_push;
  endproperty
  a_overrun_error_flag_block: assert property (p_overrun_error_flag_block) else $error("transfer during overrun"); // RULE_18

  property p_rx_abort;
    @(posedge i_clk) disable iff (!i_rst_b) !cont_rx |=> !overrun && rx_cnt == 4'h0;
  endproperty
  a_rx_abort: assert property (p_rx_abort) else $error("receive not reset on abort"); // RULE_15

  property p_sample_fall;
    @(posedge i_clk) disable iff (!i_rst_b) rx_go && !ck_fall |=> rx_shift == $past(rx_shift);
  endproperty
  a_sample_fall: assert property (p_sample_fall) else $error("sampled off the falling edge"); // RULE_16
endmodule
`default_nettype wire

// file: verilog/uss_pkg.sv
/*
  Constants for the synchronous slave serial port: the register map, field
  positions, reset values and the wake-up vector.
  Assumes a byte-wide register port with a separate bank select line.
*/
package uss_pkg;
  // Register offsets, bank 0
  localparam logic [4:0] RXCTL_ADDR = 5'h13;
  localparam logic [4:0] RXBUF_ADDR = 5'h14;
  localparam logic [4:0] TXCTL_ADDR = 5'h15;
  localparam logic [4:0] TXHOLD_ADDR = 5'h16;
  localparam logic [4:0] DIVISOR_ADDR = 5'h17;
  // Register offsets, bank 1
  localparam logic [4:0] INTREQ_ADDR = 5'h16;
  localparam logic [4:0] INTEN_ADDR = 5'h17;
  localparam logic BANK0 = 1'b0;
  localparam logic BANK1 = 1'b1;

  // Receive status and control fields
  localparam int RC_PORT_EN = 7;
  localparam int RC_NINE = 6;
  localparam int RC_SINGLE = 5;
  localparam int RC_CONT = 4;
  localparam int RC_FRAME_ERR = 2;
  localparam int RC_OVERRUN = 1;
  localparam int RC_BIT9 = 0;
  // Transmit status and control fields
  localparam int TX_CLK_SRC = 7;
  localparam int TX_NINE = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_EMPTY = 1;
  localparam int TX_BIT9 = 0;
  // Interrupt request and enable fields
  localparam int IR_TX = 1;
  localparam int IR_RX = 0;

  // Reset values
  localparam logic [7:0] RXCTL_RST = 8'h00;
  localparam logic [7:0] TXCTL_RST = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  localparam logic [1:0] INTEN_RST = 2'h0;
  localparam logic [7:0] ZERO8 = 8'h00;

  // Word shape: eight data bits, optional ninth bit
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int RXQ_WIDTH = 10;
  localparam int RXQ_DEPTH = 2;

  // Interrupt vector taken on wake with global interrupts on
  localparam logic [15:0] INT_VECTOR = 16'h0020;
endpackage

// file: verilog/uss_sync2.sv
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the input may change at any time relative to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_sync2 (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_async,
  output logic o_sync
);
  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// file: verilog/uss_rxq.sv
/*
  Two-deep receive queue holding data, ninth bit and framing flag.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_rxq (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_push,
  input wire logic [uss_pkg::RXQ_WIDTH-1:0] i_data,
  input wire logic i_pop,
  output logic [uss_pkg::RXQ_WIDTH-1:0] o_data,
  output logic o_empty,
  output logic o_full
);
  logic [uss_pkg::RXQ_WIDTH-1:0] mem [uss_pkg::RXQ_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;

  assign o_data = mem[rd_ptr];
  assign o_empty = (count == 2'h0);
  assign o_full = (count == 2'(uss_pkg::RXQ_DEPTH));

  // Storage written at the write pointer
  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (i_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (i_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, i_push} - {1'b0, i_pop};
    end
  end
endmodule
`default_nettype wire

// file: tb/uss_master_model.sv
/*
  Behavioural external master for the slave port: makes the shift clock,
  drives the data line towards the port or samples what the port sends.
  Assumes the bench resolves the data wire from the port's output enable alone.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_master_model (
  output logic o_ck,
  output logic o_dt,
  output logic o_oe,
  input wire logic i_dt_wire
);
  // Clock idles low between frames; line released
  initial begin
    o_ck = 1'b0;
    o_dt = 1'b1;
    o_oe = 1'b0;
  end

  // One frame of n bits, LSB first, 200 ns per bit; data changes on the rise
  // so that the port sees it stable at the fall
  task automatic shift(input int n, input logic drv, input logic [8:0] tx,
                       output logic [8:0] rx);
    rx = 9'h000;
    #7;
    for (int k = 0; k < n; k++) begin
      o_ck = 1'b1;
      o_oe = drv;
      o_dt = tx[k];
      #100 o_ck = 1'b0;
      // Sample soon after the fall, before the port moves to its next bit
      #25 rx[k] = i_dt_wire;
      #75;
    end
    // Released line shows the inverse of the last value
    o_oe = 1'b0;
    o_dt = ~o_dt;
  endtask
endmodule
`default_nettype wire

// file: tb/uss_port_tb.sv
/*
  Self-checking bench for the synchronous slave serial port: register
  tasks, a slow external master, transmit and receive sequences.
  Assumes the port top and the master model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_port_tb;
  logic clk, rst_b, bank, wr, rd, glob, ck, m_dt, m_oe;
  logic dt_out, dt_oe, wake, irq;
  logic [4:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] vec;
  logic [8:0] got;
  logic [8:0] words [3] = '{9'h111, 9'h022, 9'h133};
  wire dt_wire;
  int miscompares = 0;
  int tests_run = 0;

  // Clock at 40 MHz
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  uss_port i_uss_port (.i_clk(clk), .i_rst_b(rst_b), .i_bank(bank), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ck_pin(ck),
    .i_dt_in(dt_wire), .o_dt_out(dt_out), .o_dt_oe(dt_oe), .i_glob_int_en(glob),
    .o_wake(wake), .o_irq(irq), .o_vector(vec));
  uss_master_model i_uss_master_model (.o_ck(ck), .o_dt(m_dt), .o_oe(m_oe),
    .i_dt_wire(dt_wire));
  // Shared data wire: the port wins while it drives
  assign dt_wire = dt_oe ? dt_out : m_dt;

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register access; ba is bank then offset
  task automatic wr_reg(input logic [5:0] ba, input logic [7:0] d);
    @(posedge clk);
    bank <= ba[5];
    addr <= ba[4:0];
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] ba, output logic [7:0] d);
    @(posedge clk);
    bank <= ba[5];
    addr <= ba[4:0];
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdc(input string what, input logic [5:0] ba, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(ba, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask

  // Bounded poll of masked bits; running out ends the run
  task automatic poll(input string what, input logic [5:0] ba, input logic [7:0] m,
                      input logic [7:0] exp);
    logic [7:0] d;
    for (int n = 0; n < 40; n++) begin
      rd_reg(ba, d);
      if ((d & m) === exp) break;
    end
    chk(what, {8'h00, exp}, {8'h00, d & m});
    if ((d & m) !== exp) report_and_stop();
  endtask

  task automatic frame(input int n, input logic drv, input logic [8:0] tx);
    i_uss_master_model.shift(n, drv, tx, got);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    bank = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    glob = 1'b0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rdc("rcv status", 6'h13, 8'h00);
    rdc("tx status", 6'h15, 8'h02);
    rdc("int request", 6'h36, 8'h02);
    rdc("int enable", 6'h37, 8'h00);
    rdc("unmapped", 6'h00, 8'h00);
    wr_reg(6'h17, 8'hA5);
    rdc("divisor", 6'h17, 8'hA5);
    rdc("tx holding", 6'h16, 8'h00);
    chk("vector", 16'h0020, vec);
    $display("Test registers done");

    // Two words queued; second waits until the first is out
    @(posedge clk);
    glob <= 1'b1;
    wr_reg(6'h13, 8'h80);
    wr_reg(6'h37, 8'h02);
    wr_reg(6'h16, 8'h3C);
    rdc("tx flag full", 6'h36, 8'h00);
    wr_reg(6'h15, 8'h30);
    poll("first moved", 6'h36, 8'h02, 8'h02);
    chk("tx wake", 16'h0003, {14'h0000, wake, irq});
    wr_reg(6'h16, 8'hC3);
    rdc("second held", 6'h36, 8'h00);
    chk("no wake", 16'h0000, {15'h0000, wake});
    rdc("shifting", 6'h15, 8'h30);
    frame(8, 1'b0, 9'h000);
    chk("word one", 16'h003C, {7'h00, got});
    poll("second moved", 6'h36, 8'h02, 8'h02);
    frame(8, 1'b0, 9'h000);
    chk("word two", 16'h00C3, {7'h00, got});
    poll("shift empty", 6'h15, 8'h02, 8'h02);
    // Ninth bit, latched at load
    wr_reg(6'h15, 8'h51);
    wr_reg(6'h16, 8'h96);
    wr_reg(6'h15, 8'h71);
    frame(9, 1'b0, 9'h000);
    chk("nine bit", 16'h0196, {7'h00, got});
    // Abort in mid-word, then restart clean
    wr_reg(6'h16, 8'hFF);
    frame(3, 1'b0, 9'h000);
    wr_reg(6'h15, 8'h10);
    poll("abort empty", 6'h15, 8'h02, 8'h02);
    chk("abort oe", 16'h0000, {15'h0000, dt_oe});
    wr_reg(6'h16, 8'h5A);
    wr_reg(6'h15, 8'h30);
    frame(8, 1'b0, 9'h000);
    chk("restart", 16'h005A, {7'h00, got});
    $display("Test transmit done");

    // Single receive enable alone receives nothing
    wr_reg(6'h15, 8'h10);
    wr_reg(6'h37, 8'h01);
    wr_reg(6'h13, 8'hA0);
    frame(8, 1'b1, 9'h0AA);
    repeat (8) @(posedge clk);
    rdc("single ignored", 6'h36, 8'h02);
    // Three nine-bit words into a two-deep queue
    wr_reg(6'h13, 8'hD0);
    frame(9, 1'b1, words[0]);
    poll("rx flag", 6'h36, 8'h01, 8'h01);
    chk("rx wake", 16'h0003, {14'h0000, wake, irq});
    for (int i = 1; i < 3; i++) begin
      frame(9, 1'b1, words[i]);
    end
    poll("overrun", 6'h13, 8'hFF, 8'hD3);
    rdc("head", 6'h14, 8'h11);
    rdc("next status", 6'h13, 8'hD2);
    rdc("second", 6'h14, 8'h22);
    poll("drained", 6'h36, 8'h01, 8'h00);
    frame(9, 1'b1, 9'h044);
    repeat (8) @(posedge clk);
    rdc("blocked", 6'h36, 8'h02);
    wr_reg(6'h13, 8'hC0);
    poll("overrun cleared", 6'h13, 8'hFE, 8'hC0);
    // Abort a partial word, then a clean word arrives whole
    wr_reg(6'h13, 8'hD0);
    frame(4, 1'b1, 9'h1FF);
    wr_reg(6'h13, 8'hC0);
    wr_reg(6'h13, 8'hD0);
    frame(9, 1'b1, 9'h081);
    poll("clean flag", 6'h36, 8'h01, 8'h01);
    rdc("clean status", 6'h13, 8'hD0);
    rdc("clean word", 6'h14, 8'h81);
    $display("Test receive done");
    report_and_stop();
  end
endmodule
`default_nettype wire
